// ---- prescaled_timer_capture_match.sv ----
// prescaled_timer_capture_match: 32-bit timer with prescaler, four compares, two captures
// assumes: APB master on pclk, capture inputs asynchronous to pclk, zero wait states
`default_nettype none

module prescaled_timer_capture_match
	import timer_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] capture_input,
	output logic [3:0] compare_output
);

	// ==========================================================
	// state
	timer_state_s state_reg;
	timer_state_s state_next;

	logic bus_wr;
	logic bus_acc;
	logic addr_hit;
	logic [1:0] rise;
	logic [1:0] fall;
	logic [1:0] cap_evt;
	logic cnt_edge;
	logic counting;
	logic tick;
	logic [3:0] match;
	logic any_rst;
	logic any_stop;
	pin_action_e act;

	// ==========================================================
	// apb decode
	assign bus_acc = psel & penable;
	assign bus_wr = bus_acc & pwrite;
	assign pready = 1'b1;
	assign pslverr = bus_acc & ~addr_hit;

	// address hit for mapped registers
	always_comb begin
		if (paddr == OFF_FLAGS || paddr == OFF_CTRL || paddr == OFF_COUNT) begin
			addr_hit = 1'b1;
		end else if (paddr == OFF_LIMIT || paddr == OFF_DIV || paddr == OFF_ACTION) begin
			addr_hit = 1'b1;
		end else if (paddr == OFF_CMP0 || paddr == OFF_CMP1) begin
			addr_hit = 1'b1;
		end else if (paddr == OFF_CMP2 || paddr == OFF_CMP3) begin
			addr_hit = 1'b1;
		end else if (paddr == OFF_EDGE || paddr == OFF_CAP0 || paddr == OFF_CAP1) begin
			addr_hit = 1'b1;
		end else if (paddr == OFF_PINS || paddr == OFF_SOURCE || paddr == OFF_PWM) begin
			addr_hit = 1'b1;
		end else begin
			addr_hit = 1'b0;
		end
	end

	// read mux, reserved bits read zero
	always_comb begin
		prdata = RESET_WORD;
		if (!(psel && !pwrite)) begin
			prdata = RESET_WORD;
		end else if (paddr == OFF_FLAGS) begin
			prdata = {26'h0, state_reg.flags};
		end else if (paddr == OFF_CTRL) begin
			prdata = {30'h0, state_reg.ctrl};
		end else if (paddr == OFF_COUNT) begin
			prdata = state_reg.count;
		end else if (paddr == OFF_LIMIT) begin
			prdata = state_reg.limit;
		end else if (paddr == OFF_DIV) begin
			prdata = state_reg.div;
		end else if (paddr == OFF_ACTION) begin
			prdata = {20'h0, state_reg.action};
		end else if (paddr == OFF_CMP0) begin
			prdata = state_reg.cmp[0];
		end else if (paddr == OFF_CMP1) begin
			prdata = state_reg.cmp[1];
		end else if (paddr == OFF_CMP2) begin
			prdata = state_reg.cmp[2];
		end else if (paddr == OFF_CMP3) begin
			prdata = state_reg.cmp[3];
		end else if (paddr == OFF_EDGE) begin
			prdata = {26'h0, state_reg.edges};
		end else if (paddr == OFF_CAP0) begin
			prdata = state_reg.cap[0];
		end else if (paddr == OFF_CAP1) begin
			prdata = state_reg.cap[1];
		end else if (paddr == OFF_PINS) begin
			prdata = {20'h0, state_reg.pins};
		end else if (paddr == OFF_SOURCE) begin
			prdata = {29'h0, state_reg.source};
		end else if (paddr == OFF_PWM) begin
			prdata = {28'h0, state_reg.pwm};
		end
	end

	// ==========================================================
	// input edges, taken from the second synchroniser stage only
	assign rise = state_reg.sync2 & ~state_reg.prev;
	assign fall = ~state_reg.sync2 & state_reg.prev;

	// capture events per selected edge
	always_comb begin
		for (int j = 0; j < 2; j++) begin
			cap_evt[j] = (rise[j] & state_reg.edges[EDGE_STRIDE*j+EDGE_RISE])
				| (fall[j] & state_reg.edges[EDGE_STRIDE*j+EDGE_FALL]);
		end
	end

	// counter-mode edge on the chosen input
	always_comb begin
		case (count_mode_e'(state_reg.source[1:0]))
			COUNT_RISE: cnt_edge = rise[state_reg.source[SOURCE_SEL]];
			COUNT_FALL: cnt_edge = fall[state_reg.source[SOURCE_SEL]];
			COUNT_BOTH: cnt_edge = rise[state_reg.source[SOURCE_SEL]]
				| fall[state_reg.source[SOURCE_SEL]];
			default: cnt_edge = 1'b0;
		endcase
	end

	// ==========================================================
	// counting enable and timer tick
	assign counting = state_reg.ctrl[CTRL_ENABLE] & ~state_reg.ctrl[CTRL_CLEAR];
	always_comb begin
		if (state_reg.source[1:0] == COUNT_TIMER) begin
			tick = counting && (state_reg.div == state_reg.limit);
		end else begin
			tick = counting && cnt_edge;
		end
	end

	// compare matches are taken on the tick that leaves the matching value
	always_comb begin
		any_rst = 1'b0;
		any_stop = 1'b0;
		for (int i = 0; i < 4; i++) begin
			match[i] = tick && (state_reg.count == state_reg.cmp[i]);
			any_rst = any_rst | (match[i] & state_reg.action[ACT_STRIDE*i+ACT_RST]);
			any_stop = any_stop | (match[i] & state_reg.action[ACT_STRIDE*i+ACT_STOP]);
		end
	end

	// ==========================================================
	// next state
	always_comb begin
		state_next = state_reg;
		act = PIN_KEEP;

		// two-stage synchroniser and edge history
		state_next.sync1 = capture_input;
		state_next.sync2 = state_reg.sync1;
		state_next.prev = state_reg.sync2;

		// divider count runs only in timer mode
		if (counting && state_reg.source[1:0] == COUNT_TIMER) begin
			if (tick) begin
				state_next.div = 32'h0;
			end else begin
				state_next.div = state_reg.div + 32'h1;
			end
		end

		// timer count advance, wraps freely with no flag
		if (tick) begin
			if (any_rst) begin
				state_next.count = 32'h0;
			end else if (any_stop) begin
				state_next.count = state_reg.count;
			end else begin
				state_next.count = state_reg.count + 32'h1;
			end
		end
		if (any_stop) begin
			state_next.div = 32'h0;
			state_next.ctrl[CTRL_ENABLE] = 1'b0;
		end

		// interrupt flags: compare and capture events set
		for (int i = 0; i < 4; i++) begin
			if (match[i] && state_reg.action[ACT_STRIDE*i+ACT_INT]) begin
				state_next.flags[i] = 1'b1;
			end
		end
		for (int j = 0; j < 2; j++) begin
			if (cap_evt[j]) begin
				state_next.cap[j] = state_reg.count;
				if (state_reg.edges[EDGE_STRIDE*j+EDGE_INT]) begin
					state_next.flags[FLAG_CAP_BASE+j] = 1'b1;
				end
			end
		end

		// compare outputs: pulse-width level or match action
		for (int i = 0; i < 4; i++) begin
			act = pin_action_e'(state_reg.pins[PIN_ACT_BASE+2*i +: 2]);
			if (state_reg.pwm[i]) begin
				state_next.pins[i] = (state_reg.count >= state_reg.cmp[i]);
			end else if (match[i]) begin
				case (act)
					PIN_LOW: state_next.pins[i] = 1'b0;
					PIN_HIGH: state_next.pins[i] = 1'b1;
					PIN_TOGGLE: state_next.pins[i] = ~state_reg.pins[i];
					default: state_next.pins[i] = state_reg.pins[i];
				endcase
			end
		end

		// synchronous software reset holds both counters at zero
		if (state_reg.ctrl[CTRL_CLEAR]) begin
			state_next.count = 32'h0;
			state_next.div = 32'h0;
		end

		// bus writes; flag clear beats a same-cycle set only when the flag was already set
		if (bus_wr) begin
			if (paddr == OFF_FLAGS) begin
				state_next.flags = state_next.flags
					& ~(pwdata[FLAGS_W-1:0] & ~(state_next.flags & ~state_reg.flags));
			end else if (paddr == OFF_CTRL) begin
				state_next.ctrl = pwdata[CTRL_W-1:0];
			end else if (paddr == OFF_COUNT) begin
				state_next.count = pwdata;
			end else if (paddr == OFF_LIMIT) begin
				state_next.limit = pwdata;
			end else if (paddr == OFF_DIV) begin
				state_next.div = pwdata;
			end else if (paddr == OFF_ACTION) begin
				state_next.action = pwdata[ACT_W-1:0];
			end else if (paddr == OFF_CMP0) begin
				state_next.cmp[0] = pwdata;
			end else if (paddr == OFF_CMP1) begin
				state_next.cmp[1] = pwdata;
			end else if (paddr == OFF_CMP2) begin
				state_next.cmp[2] = pwdata;
			end else if (paddr == OFF_CMP3) begin
				state_next.cmp[3] = pwdata;
			end else if (paddr == OFF_EDGE) begin
				state_next.edges = pwdata[EDGE_W-1:0];
			end else if (paddr == OFF_PINS) begin
				state_next.pins = pwdata[PINS_W-1:0];
			end else if (paddr == OFF_SOURCE) begin
				state_next.source = pwdata[SOURCE_W-1:0];
			end else if (paddr == OFF_PWM) begin
				state_next.pwm = pwdata[PWM_W-1:0];
			end
		end
	end

	// ==========================================================
	// state register, all zero at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// compare pins come straight from the stored levels
	assign compare_output = state_reg.pins[3:0];

endmodule : prescaled_timer_capture_match

`default_nettype wire

// ---- prescaled_timer_capture_match_bench.sv ----
// prescaled_timer_capture_match_bench: self-checking bench over APB
// assumes: timer_pkg and the checker compiled first
`default_nettype none
module prescaled_timer_capture_match_bench;
	import timer_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [1:0] capture_input;
	logic [3:0] compare_output;
	int n_fail, checked, cyc;
	prescaled_timer_capture_match i_prescaled_timer_capture_match (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .capture_input,
		.compare_output);
	// ==========
	// clock and hang guard
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			close_out();
		end
	end
	// ==========
	// shared tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task bus(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		d = prdata;
		psel <= 0;
		penable <= 0;
	endtask : bus
	task wr(input logic [11:0] a, input logic [31:0] v);
		bus(1, a, v);
	endtask : wr
	task rc(input logic [11:0] a, input logic [31:0] exp);
		bus(0, a, 32'h0);
		chk(d, exp);
	endtask : rc
	task waitc(input int n);
		repeat (n) @(posedge pclk);
	endtask : waitc
	task close_out;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	// ==========
	// scenarios
	task t_reset;
		logic [11:0] offs [16];
		offs = '{OFF_FLAGS, OFF_CTRL, OFF_COUNT, OFF_LIMIT, OFF_DIV, OFF_ACTION, OFF_CMP0,
			OFF_CMP1, OFF_CMP2, OFF_CMP3, OFF_EDGE, OFF_CAP0, OFF_CAP1, OFF_PINS, OFF_SOURCE,
			OFF_PWM};
		foreach (offs[i]) rc(offs[i], 32'h0);
		rc(12'h034, 32'h0);
		$display("reset values done");
	endtask : t_reset
	task t_prescale;
		wr(OFF_LIMIT, 32'h3);
		wr(OFF_CMP0, 32'h5);
		wr(OFF_ACTION, 32'h5);
		wr(OFF_PINS, 32'h20);
		wr(OFF_CTRL, 32'h1);
		waitc(7);
		rc(OFF_DIV, 32'h1);
		rc(OFF_COUNT, 32'h3);
		rc(OFF_CTRL, 32'h1);
		waitc(20);
		rc(OFF_CTRL, 32'h0);
		rc(OFF_COUNT, 32'h5);
		rc(OFF_DIV, 32'h0);
		rc(OFF_FLAGS, 32'h1);
		chk(compare_output, 4'h1);
		wr(OFF_FLAGS, 32'h0);
		rc(OFF_FLAGS, 32'h1);
		wr(OFF_FLAGS, 32'h3f);
		rc(OFF_FLAGS, 32'h0);
		wr(OFF_CTRL, 32'h2);
		rc(OFF_COUNT, 32'h0);
		wr(OFF_CTRL, 32'h0);
		$display("prescale and match done");
	endtask : t_prescale
	task t_wrap;
		wr(OFF_ACTION, 32'h0);
		wr(OFF_LIMIT, 32'h0);
		wr(OFF_COUNT, 32'hffffffff);
		wr(OFF_CTRL, 32'h1);
		rc(OFF_COUNT, 32'h1);
		wr(OFF_CTRL, 32'h0);
		rc(OFF_FLAGS, 32'h0);
		$display("wrap done");
	endtask : t_wrap
	task t_capture;
		wr(OFF_COUNT, 32'h1234);
		wr(OFF_EDGE, 32'h15);
		capture_input <= 2'b01;
		waitc(5);
		rc(OFF_CAP0, 32'h1234);
		rc(OFF_FLAGS, 32'h10);
		wr(OFF_CAP0, 32'hffff);
		wr(OFF_COUNT, 32'h55);
		capture_input <= 2'b10;
		waitc(5);
		wr(OFF_COUNT, 32'h77);
		capture_input <= 2'b00;
		waitc(5);
		rc(OFF_CAP0, 32'h1234);
		rc(OFF_CAP1, 32'h77);
		rc(OFF_FLAGS, 32'h10);
		wr(OFF_FLAGS, 32'h3f);
		$display("capture done");
	endtask : t_capture
	task t_count;
		wr(OFF_COUNT, 32'h0);
		wr(OFF_SOURCE, 32'h1);
		wr(OFF_CTRL, 32'h1);
		repeat (3) begin
			capture_input <= 2'b01;
			waitc(4);
			capture_input <= 2'b00;
			waitc(4);
		end
		waitc(3);
		rc(OFF_COUNT, 32'h3);
		wr(OFF_CTRL, 32'h0);
		wr(OFF_SOURCE, 32'h0);
		$display("counter mode done");
	endtask : t_count
	task t_pwm;
		wr(OFF_COUNT, 32'h4);
		wr(OFF_PWM, 32'h1);
		waitc(2);
		chk(compare_output, 4'h0);
		wr(OFF_COUNT, 32'h6);
		waitc(2);
		chk(compare_output, 4'h1);
		$display("pulse width done");
	endtask : t_pwm
	// ==========
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, capture_input} = '0;
		{n_fail, checked, cyc} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1;
		t_reset();
		t_prescale();
		t_wrap();
		t_capture();
		t_count();
		t_pwm();
		close_out();
	end
endmodule : prescaled_timer_capture_match_bench
`default_nettype wire

// ---- timer_chk_properties.sv ----
// timer_chk_properties: port assertions for the prescaled timer
// assumes: bound to prescaled_timer_capture_match, single clock pclk
`default_nettype none
module timer_chk_properties
	import timer_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] capture_input,
	input wire logic [3:0] compare_output
);
	// ==========
	// access phase decode
	wire logic acc = psel && penable;
	wire logic rd = acc && !pwrite;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========
	// bus answers
	chk_ready_high: assert property (pready)
		else $error("pready low");
	chk_unmapped_err: assert property (acc && paddr == 12'h034 |-> pslverr)
		else $error("no error on unmapped");
	chk_mapped_ok: assert property (acc && paddr == OFF_COUNT |-> !pslverr)
		else $error("error on mapped");
	chk_cap_ro: assert property (acc && pwrite && paddr == OFF_CAP0 |-> !pslverr)
		else $error("error on capture write");
	// ==========
	// reserved bits read zero
	chk_flags_resv: assert property (rd && paddr == OFF_FLAGS |-> prdata[31:6] == 26'h0)
		else $error("flag reserved bits set");
	chk_ctrl_resv: assert property (rd && paddr == OFF_CTRL |-> prdata[31:2] == 30'h0)
		else $error("control reserved bits set");
	chk_src_resv: assert property (rd && paddr == OFF_SOURCE |-> prdata[31:3] == 29'h0)
		else $error("source reserved bits set");
	chk_pwm_resv: assert property (rd && paddr == OFF_PWM |-> prdata[31:4] == 28'h0)
		else $error("pwm reserved bits set");
	// ==========
	// compare pins
	chk_pins_reset: assert property ($rose(presetn) |-> compare_output == 4'h0)
		else $error("pins not zero after reset");
	chk_pin_write: assert property (acc && pwrite && paddr == OFF_PINS
		|=> compare_output == $past(pwdata[3:0]))
		else $error("pin level not written");
endmodule : timer_chk_properties

bind prescaled_timer_capture_match timer_chk_properties i_timer_chk_properties (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .capture_input,
	.compare_output);
`default_nettype wire

// ---- timer_pkg.sv ----
// timer_pkg: register map, field positions and mode codes for the prescaled timer
// assumes: one 100 MHz peripheral clock, APB access with 32-bit aligned words
`default_nettype none

package timer_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [11:0] OFF_FLAGS = 12'h000;
	localparam logic [11:0] OFF_CTRL = 12'h004;
	localparam logic [11:0] OFF_COUNT = 12'h008;
	localparam logic [11:0] OFF_LIMIT = 12'h00c;
	localparam logic [11:0] OFF_DIV = 12'h010;
	localparam logic [11:0] OFF_ACTION = 12'h014;
	localparam logic [11:0] OFF_CMP0 = 12'h018;
	localparam logic [11:0] OFF_CMP1 = 12'h01c;
	localparam logic [11:0] OFF_CMP2 = 12'h020;
	localparam logic [11:0] OFF_CMP3 = 12'h024;
	localparam logic [11:0] OFF_EDGE = 12'h028;
	localparam logic [11:0] OFF_CAP0 = 12'h02c;
	localparam logic [11:0] OFF_CAP1 = 12'h030;
	localparam logic [11:0] OFF_PINS = 12'h03c;
	localparam logic [11:0] OFF_SOURCE = 12'h070;
	localparam logic [11:0] OFF_PWM = 12'h074;

	// ==========================================================
	// field positions
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_CLEAR = 1;
	localparam int FLAG_CAP_BASE = 4;
	localparam int ACT_INT = 0;
	localparam int ACT_RST = 1;
	localparam int ACT_STOP = 2;
	localparam int ACT_STRIDE = 3;
	localparam int EDGE_RISE = 0;
	localparam int EDGE_FALL = 1;
	localparam int EDGE_INT = 2;
	localparam int EDGE_STRIDE = 3;
	localparam int PIN_ACT_BASE = 4;
	localparam int SOURCE_SEL = 2;

	// widths of implemented fields
	localparam int FLAGS_W = 6;
	localparam int CTRL_W = 2;
	localparam int ACT_W = 12;
	localparam int EDGE_W = 6;
	localparam int PINS_W = 12;
	localparam int SOURCE_W = 3;
	localparam int PWM_W = 4;

	// ==========================================================
	// reset values
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// ==========================================================
	// count source and pin action codes
	typedef enum logic [1:0] {
		COUNT_TIMER = 2'b00,
		COUNT_RISE = 2'b01,
		COUNT_FALL = 2'b10,
		COUNT_BOTH = 2'b11
	} count_mode_e;

	typedef enum logic [1:0] {
		PIN_KEEP = 2'b00,
		PIN_LOW = 2'b01,
		PIN_HIGH = 2'b10,
		PIN_TOGGLE = 2'b11
	} pin_action_e;

	// all state of the timer block
	typedef struct packed {
		logic [FLAGS_W-1:0] flags;
		logic [CTRL_W-1:0] ctrl;
		logic [31:0] count;
		logic [31:0] limit;
		logic [31:0] div;
		logic [ACT_W-1:0] action;
		logic [3:0][31:0] cmp;
		logic [EDGE_W-1:0] edges;
		logic [1:0][31:0] cap;
		logic [PINS_W-1:0] pins;
		logic [SOURCE_W-1:0] source;
		logic [PWM_W-1:0] pwm;
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [1:0] prev;
	} timer_state_s;

endpackage : timer_pkg

`default_nettype wire
